// ==== pms_regs.svh ====
`ifndef PMS_REGS_SVH
`define PMS_REGS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PMS_OFF_CMD 8'h00
`define PMS_OFF_CFG 8'h04
`define PMS_OFF_SEGLEN 8'h08
`define PMS_OFF_EVTIME 8'h0C
`define PMS_OFF_LSP 8'h10
`define PMS_OFF_MPO 8'h14
`define PMS_OFF_MANOUT 8'h18
`define PMS_OFF_STATUS 8'h1C
`define PMS_OFF_TIMER 8'h20
`define PMS_OFF_STARTSEG 8'h24
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PMS_CMD_OP_LSB 0
`define PMS_CMD_SRC_LSB 4
`define PMS_CFG_SEGCNT_LSB 0
`define PMS_CFG_REPEND_LSB 6
`define PMS_CFG_REPSTART_LSB 12
`define PMS_CFG_REPCNT_LSB 18
`define PMS_CFG_LINKLOC_BIT 26
`define PMS_CFG_MPOEN_BIT 27
`define PMS_CFG_IOFF_BIT 28
`define PMS_CFG_LOCASSIGN_BIT 29
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PMS_CFG_RESET 32'h0000_0001
`define PMS_SEGLEN_RESET 16'h0010
`define PMS_EVTIME_RESET 32'h0000_0000
`define PMS_FIRST_SEG 6'h01
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PMS_CLK_NS 10
`define PMS_TICK_NS 1000000
`define PMS_TICK_CYCLES (`PMS_TICK_NS / `PMS_CLK_NS)
`endif

// ==== pms_pkg.sv ====
package pms_pkg;
  typedef enum logic [3:0] {
    PMS_RST = 4'b0001,
    PMS_PROGRAM_RUN = 4'b0010,
    PMS_HOLD = 4'b0100,
    PMS_LOCAL = 4'b1000
  } pms_mode_t;

  typedef enum logic [3:0] {
    PMS_OP_NONE = 4'h0,
    PMS_OP_HOLD_ON = 4'h1,
    PMS_OP_HOLD_OFF = 4'h2,
    PMS_OP_SKIP = 4'h3,
    PMS_OP_RESET = 4'h4,
    PMS_OP_PROGRAM_RUN = 4'h5,
    PMS_OP_LOCAL = 4'h6,
    PMS_OP_AUTO = 4'h7,
    PMS_OP_MAN = 4'h8
  } pms_op_t;

  typedef enum logic [1:0] {
    PMS_SRC_KEY = 2'h0,
    PMS_SRC_PARAM = 2'h1,
    PMS_SRC_COMM = 2'h2,
    PMS_SRC_CONTACT = 2'h3
  } pms_src_t;
endpackage : pms_pkg

// ==== pms_sync.sv ====
`timescale 1ns/1ps
module pms_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic ce,
  // pins in, filtered levels out
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] levelOut
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // a change is taken only once the second and third stages agree
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          s1_r[i] <= 1'b0;
          s2_r[i] <= 1'b0;
          s3_r[i] <= 1'b0;
          levelOut[i] <= 1'b0;
        end else if (ce) begin
          s1_r[i] <= pinIn[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          if (s2_r[i] == s3_r[i]) begin
            levelOut[i] <= s3_r[i];
          end
        end
      end
    end
  endgenerate
endmodule : pms_sync

// ==== pms_top.sv ====
`timescale 1ns/1ps
`include "pms_regs.svh"
// Notes on behaviour
// - pause on suspends, pause off resumes
// - pause requests only while program runs
// - pause from key, parameter, contact, comm
// - key or parameter change shows setpoint view
// - pause freezes segment and event timers
// - resume continues timers from frozen values
// - pause keeps setpoint from pause start
// - pause holds time events, pv events run
// - pause lamp lit while paused
// - skip moves to next segment
// - skip only while running or paused, four sources
// - skip in last segment: reset or local
// - skip in repeat end segment repeats
// - skip during pause clears pause
// - skip ends segment time and events
// - auto/manual contact on rejects others
// - contact off: latest request applies
// - to manual holds output or preset
// - manual output set directly
// - to auto bumpless unless integral off
// - local uses local setpoint, no time events
// - mode values reset, program, local
// - local menu hidden when contact assigned
// - reset forces all events off
// - reset, local, power-up: start segment one
module pms_top #(
  parameter int TICK_CYCLES = `PMS_TICK_CYCLES,
  parameter int NPV = 2,
  parameter int VW = 16
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // contact inputs
  input wire logic contHold,
  input wire logic contSkip,
  input wire logic contAm,
  input wire logic contRun,
  input wire logic contReset,
  input wire logic contLocal,
  // process side
  input wire logic [VW-1:0] programSp,
  input wire logic [VW-1:0] autoOut,
  input wire logic [NPV-1:0] pvEventIn,
  // control outputs
  output logic [VW-1:0] activeSp,
  output logic [VW-1:0] ctrlOut,
  output logic bumplessLoad,
  output logic timeEventOut,
  output logic [NPV-1:0] pvEventOut,
  // lamps and display
  output logic pauseLamp,
  output logic manLamp,
  output logic rstLamp,
  output logic showSpView,
  output logic showOutView,
  output logic hideLocalMenu
);
  // ----------------------------------------------------------------
  // contact synchronisers
  // ----------------------------------------------------------------
  logic [5:0] cLvl;
  logic [5:0] cPrev_r;
  pms_sync #(.WIDTH(6)) u_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .ce(ce),
    .pinIn({contLocal, contReset, contRun, contAm, contSkip, contHold}),
    .levelOut(cLvl)
  );
  wire [5:0] cRise = cLvl & ~cPrev_r;
  wire [5:0] cFall = ~cLvl & cPrev_r;
  wire amContact = cLvl[2];

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  logic dWr_r;
  logic [7:0] dAddr_r;
  logic [31:0] cfg_r;
  logic [VW-1:0] segLen_r;
  logic [31:0] evTime_r;
  logic [VW-1:0] lsp_r;
  logic [VW-1:0] mpo_r;
  logic [VW-1:0] manOut_r;
  logic [5:0] startSeg_r;
  logic [5:0] seg_r;
  logic [VW-1:0] elapsed_r;
  logic manual_r;
  pms_pkg::pms_mode_t mode_r;
  pms_pkg::pms_mode_t modeNxt;

  wire aValid = hsel & htrans[1] & hready;
  wire aWr = aValid & hwrite;
  wire aRd = aValid & ~hwrite;
  wire wCmd = dWr_r & (dAddr_r == `PMS_OFF_CMD);
  wire wCfg = dWr_r & (dAddr_r == `PMS_OFF_CFG);
  wire wSegLen = dWr_r & (dAddr_r == `PMS_OFF_SEGLEN);
  wire wEv = dWr_r & (dAddr_r == `PMS_OFF_EVTIME);
  wire wLsp = dWr_r & (dAddr_r == `PMS_OFF_LSP);
  wire wMpo = dWr_r & (dAddr_r == `PMS_OFF_MPO);
  wire wMan = dWr_r & (dAddr_r == `PMS_OFF_MANOUT);
  wire wStart = dWr_r & (dAddr_r == `PMS_OFF_STARTSEG);
  wire [31:0] statusWord = {12'h000, startSeg_r, seg_r, 2'h0, manual_r,
                            amContact, mode_r};
  wire [7:0] rAddr = haddr[7:0];
  wire [31:0] rdMux =
    (rAddr == `PMS_OFF_CFG) ? cfg_r :
    (rAddr == `PMS_OFF_SEGLEN) ? {16'h0000, segLen_r} :
    (rAddr == `PMS_OFF_EVTIME) ? evTime_r :
    (rAddr == `PMS_OFF_LSP) ? {16'h0000, lsp_r} :
    (rAddr == `PMS_OFF_MPO) ? {16'h0000, mpo_r} :
    (rAddr == `PMS_OFF_MANOUT) ? {16'h0000, manOut_r} :
    (rAddr == `PMS_OFF_STATUS) ? statusWord :
    (rAddr == `PMS_OFF_TIMER) ? {16'h0000, elapsed_r} :
    (rAddr == `PMS_OFF_STARTSEG) ? {26'h0000000, startSeg_r} :
    32'h0000_0000;

  // read data is sampled in the address phase so it leaves a flop
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dWr_r <= 1'b0;
      dAddr_r <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (ce) begin
      dWr_r <= aWr;
      dAddr_r <= haddr[7:0];
      if (aRd) begin
        hrdata <= rdMux;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r <= `PMS_CFG_RESET;
      segLen_r <= `PMS_SEGLEN_RESET;
      evTime_r <= `PMS_EVTIME_RESET;
      lsp_r <= 16'h0000;
      mpo_r <= 16'h0000;
    end else if (ce) begin
      if (wCfg) cfg_r <= hwdata;
      if (wSegLen) segLen_r <= hwdata[VW-1:0];
      if (wEv) evTime_r <= hwdata;
      if (wLsp) lsp_r <= hwdata[VW-1:0];
      if (wMpo) mpo_r <= hwdata[VW-1:0];
    end
  end

  wire [5:0] segCount = cfg_r[`PMS_CFG_SEGCNT_LSB +: 6];
  wire [5:0] repEnd = cfg_r[`PMS_CFG_REPEND_LSB +: 6];
  wire [5:0] repStart = cfg_r[`PMS_CFG_REPSTART_LSB +: 6];
  wire [7:0] repCount = cfg_r[`PMS_CFG_REPCNT_LSB +: 8];
  wire linkLocal = cfg_r[`PMS_CFG_LINKLOC_BIT];
  wire mpoEnable = cfg_r[`PMS_CFG_MPOEN_BIT];
  wire integralOff = cfg_r[`PMS_CFG_IOFF_BIT];
  wire localAssigned = cfg_r[`PMS_CFG_LOCASSIGN_BIT];

  // ----------------------------------------------------------------
  // request arbitration
  // ----------------------------------------------------------------
  // only one bus write lands per cycle, so the bus sources cannot
  // collide with each other; the contact simply outranks the bus
  wire [3:0] busOp = hwdata[`PMS_CMD_OP_LSB +: 4];
  wire [1:0] busSrc = hwdata[`PMS_CMD_SRC_LSB +: 2];
  // key local choice is hidden when a contact owns local switching
  wire busLocalHidden = (busOp == pms_pkg::PMS_OP_LOCAL) &
                        (busSrc == pms_pkg::PMS_SRC_KEY) & localAssigned;
  wire busValid = wCmd & (busSrc != pms_pkg::PMS_SRC_CONTACT) &
                  ~busLocalHidden;
  wire [3:0] contOp =
    cRise[1] ? pms_pkg::PMS_OP_SKIP :
    cRise[0] ? pms_pkg::PMS_OP_HOLD_ON :
    cFall[0] ? pms_pkg::PMS_OP_HOLD_OFF :
    cRise[4] ? pms_pkg::PMS_OP_RESET :
    cRise[5] ? pms_pkg::PMS_OP_LOCAL :
    cRise[3] ? pms_pkg::PMS_OP_PROGRAM_RUN :
    pms_pkg::PMS_OP_NONE;
  wire contValid = (contOp != pms_pkg::PMS_OP_NONE);
  wire [3:0] reqOp = contValid ? contOp :
                     busValid ? busOp : pms_pkg::PMS_OP_NONE;
  wire [1:0] reqSrc = contValid ? pms_pkg::PMS_SRC_CONTACT : busSrc;
  wire viewSrc = ~contValid & busValid &
                 ((busSrc == pms_pkg::PMS_SRC_KEY) |
                  (busSrc == pms_pkg::PMS_SRC_PARAM));

  // ----------------------------------------------------------------
  // segment timing
  // ----------------------------------------------------------------
  logic [31:0] tick_r;
  logic [7:0] repLeft_r;
  wire running = (mode_r == pms_pkg::PMS_PROGRAM_RUN);
  wire tickNow = (tick_r == 32'(TICK_CYCLES - 1));
  wire segDone = running & tickNow & (elapsed_r + 16'h0001 >= segLen_r);
  wire doSkip = (reqOp == pms_pkg::PMS_OP_SKIP) &
                (running | (mode_r == pms_pkg::PMS_HOLD));
  wire doAdvance = doSkip | segDone;
  wire atRepEnd = (seg_r == repEnd) & (repLeft_r != 8'h00);
  wire atLast = (seg_r >= segCount);
  wire [5:0] segAdv = atRepEnd ? repStart : seg_r + 6'h01;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_r <= 32'h0000_0000;
    end else if (ce) begin
      // the prescaler clears whenever the timers stop, so a pause drops the partial tick
      if (!running || tickNow || doAdvance) tick_r <= 32'h0000_0000;
      else tick_r <= tick_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      elapsed_r <= 16'h0000;
      seg_r <= `PMS_FIRST_SEG;
      repLeft_r <= 8'h00;
    end else if (ce) begin
      if (mode_r == pms_pkg::PMS_RST && modeNxt == pms_pkg::PMS_PROGRAM_RUN) begin
        elapsed_r <= 16'h0000;
        seg_r <= startSeg_r;
        repLeft_r <= repCount;
      end else if (doAdvance) begin
        elapsed_r <= 16'h0000;
        seg_r <= atLast && !atRepEnd ? seg_r : segAdv;
        if (atRepEnd) repLeft_r <= repLeft_r - 8'h01;
      end else if (running && tickNow) begin
        elapsed_r <= elapsed_r + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // operating mode
  // ----------------------------------------------------------------
  always_comb begin
    modeNxt = mode_r;
    case (mode_r)
      pms_pkg::PMS_RST: begin
        if (reqOp == pms_pkg::PMS_OP_PROGRAM_RUN) modeNxt = pms_pkg::PMS_PROGRAM_RUN;
        else if (reqOp == pms_pkg::PMS_OP_LOCAL) modeNxt = pms_pkg::PMS_LOCAL;
      end
      pms_pkg::PMS_PROGRAM_RUN, pms_pkg::PMS_HOLD: begin
        if (reqOp == pms_pkg::PMS_OP_RESET) begin
          modeNxt = pms_pkg::PMS_RST;
        end else if (reqOp == pms_pkg::PMS_OP_LOCAL) begin
          modeNxt = pms_pkg::PMS_LOCAL;
        end else if (doAdvance) begin
          if (atLast && !atRepEnd) begin
            modeNxt = linkLocal ? pms_pkg::PMS_LOCAL : pms_pkg::PMS_RST;
          end else begin
            modeNxt = pms_pkg::PMS_PROGRAM_RUN;
          end
        end else if (reqOp == pms_pkg::PMS_OP_HOLD_ON && running) begin
          modeNxt = pms_pkg::PMS_HOLD;
        end else if (reqOp == pms_pkg::PMS_OP_HOLD_OFF && !running) begin
          modeNxt = pms_pkg::PMS_PROGRAM_RUN;
        end
      end
      pms_pkg::PMS_LOCAL: begin
        if (reqOp == pms_pkg::PMS_OP_RESET) modeNxt = pms_pkg::PMS_RST;
        else if (reqOp == pms_pkg::PMS_OP_PROGRAM_RUN) modeNxt = pms_pkg::PMS_PROGRAM_RUN;
      end
      default: modeNxt = pms_pkg::PMS_RST;
    endcase
  end

  wire enterRstLoc = (modeNxt != mode_r) &
                     ((modeNxt == pms_pkg::PMS_RST) |
                      (modeNxt == pms_pkg::PMS_LOCAL));
  wire enterHold = (modeNxt == pms_pkg::PMS_HOLD) & running;
  wire modeChanged = (modeNxt != mode_r);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_r <= pms_pkg::PMS_RST;
      cPrev_r <= 6'h00;
      startSeg_r <= `PMS_FIRST_SEG;
    end else if (ce) begin
      mode_r <= modeNxt;
      cPrev_r <= cLvl;
      if (enterRstLoc) startSeg_r <= `PMS_FIRST_SEG;
      else if (wStart && mode_r == pms_pkg::PMS_RST) startSeg_r <= hwdata[5:0];
    end
  end

  // ----------------------------------------------------------------
  // setpoint and events
  // ----------------------------------------------------------------
  wire [VW-1:0] evOn = evTime_r[15:0];
  wire [VW-1:0] evOff = evTime_r[31:16];
  wire evWindow = (elapsed_r >= evOn) & (elapsed_r < evOff);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      activeSp <= 16'h0000;
      timeEventOut <= 1'b0;
    end else if (ce) begin
      case (mode_r)
        pms_pkg::PMS_PROGRAM_RUN: begin
          activeSp <= programSp;
          timeEventOut <= evWindow & ~doAdvance;
        end
        pms_pkg::PMS_HOLD: begin
          activeSp <= activeSp;
          timeEventOut <= doAdvance ? 1'b0 : timeEventOut;
        end
        pms_pkg::PMS_LOCAL: begin
          activeSp <= lsp_r;
          timeEventOut <= 1'b0;
        end
        default: begin
          activeSp <= activeSp;
          timeEventOut <= 1'b0;
        end
      endcase
      if (enterHold) activeSp <= programSp;
      // events drop on the edge that enters reset, not one cycle later
      if (modeNxt == pms_pkg::PMS_RST || modeNxt == pms_pkg::PMS_LOCAL) begin
        timeEventOut <= 1'b0;
      end
    end
  end

  genvar i;
  generate
    for (i = 0; i < NPV; i++) begin : g_pv
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) pvEventOut[i] <= 1'b0;
        else if (ce) pvEventOut[i] <= pvEventIn[i] &
                                      (modeNxt != pms_pkg::PMS_RST);
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // automatic / manual
  // ----------------------------------------------------------------
  wire reqMan = (reqOp == pms_pkg::PMS_OP_MAN);
  wire reqAuto = (reqOp == pms_pkg::PMS_OP_AUTO);
  // the contact level owns the choice; bus requests land only when off
  wire manNxt = amContact ? 1'b1 :
                (reqMan ? 1'b1 : (reqAuto ? 1'b0 : manual_r));
  wire toMan = manNxt & ~manual_r;
  wire toAuto = ~manNxt & manual_r;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      manual_r <= 1'b0;
      manOut_r <= 16'h0000;
      ctrlOut <= 16'h0000;
      bumplessLoad <= 1'b0;
    end else if (ce) begin
      manual_r <= manNxt;
      if (toMan) manOut_r <= mpoEnable ? mpo_r : autoOut;
      else if (wMan && manual_r) manOut_r <= hwdata[VW-1:0];
      ctrlOut <= manNxt ? (toMan ? (mpoEnable ? mpo_r : autoOut) : manOut_r)
                        : autoOut;
      bumplessLoad <= toAuto & ~integralOff;
    end
  end

  // ----------------------------------------------------------------
  // lamps and display
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pauseLamp <= 1'b0;
      manLamp <= 1'b0;
      rstLamp <= 1'b1;
      showSpView <= 1'b0;
      showOutView <= 1'b0;
      hideLocalMenu <= 1'b0;
    end else if (ce) begin
      pauseLamp <= (modeNxt == pms_pkg::PMS_HOLD);
      manLamp <= manNxt;
      rstLamp <= (modeNxt == pms_pkg::PMS_RST);
      showSpView <= viewSrc & ((modeChanged | doSkip) | (toAuto & ~amContact));
      showOutView <= viewSrc & toMan & ~amContact;
      hideLocalMenu <= localAssigned;
    end
  end

  // hsize is accepted but ignored: every transfer is served as a whole word
  wire unusedBits = ^{hsize, haddr[31:8], reqSrc};
endmodule : pms_top

// ==== pms_top_properties.sv ====
`timescale 1ns/1ps
// ----
// checker on the mode sequencer ports
// ----
module pms_chk #(
  parameter int NPV = 2,
  parameter int VW = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // watched signals
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic contAm,
  input wire logic [VW-1:0] activeSp,
  input wire logic bumplessLoad,
  input wire logic timeEventOut,
  input wire logic [NPV-1:0] pvEventOut,
  input wire logic pauseLamp,
  input wire logic manLamp,
  input wire logic rstLamp,
  input wire logic showSpView,
  input wire logic showOutView
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_reset_events: assert property
    (rstLamp |-> !timeEventOut && pvEventOut == '0)
    else $error("events active in reset");
  a_pause_mode: assert property (pauseLamp |-> !rstLamp)
    else $error("pause lamp in reset");
  a_pause_sp: assert property
    (pauseLamp && $past(pauseLamp) |-> $stable(activeSp))
    else $error("setpoint moved in pause");
  a_pause_tevent: assert property
    (pauseLamp && $past(pauseLamp) |-> $stable(timeEventOut))
    else $error("time event moved in pause");
  a_am_contact: assert property (contAm [*8] |-> manLamp)
    else $error("contact did not force manual");
  a_sp_pulse: assert property (showSpView |=> !showSpView)
    else $error("sp view pulse too long");
  a_out_pulse: assert property (showOutView |=> !showOutView)
    else $error("out view pulse too long");
  a_bump_auto: assert property (bumplessLoad |-> !manLamp)
    else $error("bumpless load in manual");

  c_pause: cover property ($rose(pauseLamp));
  c_manual: cover property ($rose(manLamp));
  c_bump: cover property (bumplessLoad);
endmodule : pms_chk

// ==== pms_panel.sv ====
`timescale 1ns/1ps
// ----
// contact-input side: switch levels follow the bench requests
// ----
module pms_panel (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // requested levels: hold skip am run reset local
  input wire logic [5:0] reqs,
  // contact pins
  output logic contHold,
  output logic contSkip,
  output logic contAm,
  output logic contRun,
  output logic contReset,
  output logic contLocal
);
  // contacts are levels, held until the operator moves them
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      {contHold, contSkip, contAm} <= 3'h0;
      {contRun, contReset, contLocal} <= 3'h0;
    end else begin
      {contHold, contSkip, contAm} <= reqs[5:3];
      {contRun, contReset, contLocal} <= reqs[2:0];
    end
  end
endmodule : pms_panel

// ==== testbench.sv ====
`timescale 1ns/1ps
`include "pms_regs.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin \
  mismatches++; $display("BAD %0t got %h want %h", $time, a, b); \
  end end
module testbench;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, q, t1;
  logic hwrite = 1'b0;
  logic [5:0] reqs = 6'h00;
  logic [15:0] programSp = 16'h0100, autoOut = 16'h0200;
  logic [1:0] pvEventIn = 2'h3;
  wire hreadyout, hresp, bumplessLoad, timeEventOut;
  wire pauseLamp, manLamp, rstLamp, showSpView, showOutView;
  wire hideLocalMenu;
  wire contHold, contSkip, contAm, contRun, contReset, contLocal;
  wire [31:0] hrdata;
  wire [15:0] activeSp, ctrlOut;
  wire [1:0] pvEventOut;
  int mismatches = 0, n_checks = 0, cyc = 0;

  always #5 sys_clk = ~sys_clk;

  pms_panel pms_panel_i (.sys_clk(sys_clk), .arst_n(arst_n),
    .reqs(reqs), .contHold(contHold), .contSkip(contSkip),
    .contAm(contAm), .contRun(contRun), .contReset(contReset),
    .contLocal(contLocal));

  pms_top #(.TICK_CYCLES(4)) pms_top_i (.sys_clk(sys_clk),
    .arst_n(arst_n), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .contHold(contHold), .contSkip(contSkip),
    .contAm(contAm), .contRun(contRun), .contReset(contReset),
    .contLocal(contLocal), .programSp(programSp), .autoOut(autoOut),
    .pvEventIn(pvEventIn), .activeSp(activeSp), .ctrlOut(ctrlOut),
    .bumplessLoad(bumplessLoad), .timeEventOut(timeEventOut),
    .pvEventOut(pvEventOut), .pauseLamp(pauseLamp), .manLamp(manLamp),
    .rstLamp(rstLamp), .showSpView(showSpView),
    .showOutView(showOutView), .hideLocalMenu(hideLocalMenu));

  // ----
  // bus master
  // ----
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge sys_clk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    r = hrdata;
    // one idle cycle lets a written command take effect; outputs are
    // looked at just after that edge, once they have settled
    @(posedge sys_clk);
    #1;
  endtask : bus

  task automatic cmd(input logic [3:0] op, input logic [1:0] src);
    logic [31:0] r;
    bus(1'b1, `PMS_OFF_CMD, {26'h0, src, op}, r);
  endtask : cmd

  task automatic status(output logic [31:0] r);
    bus(1'b0, `PMS_OFF_STATUS, 32'h0, r);
  endtask : status

  // ----
  // scenarios
  // ----
  task automatic t_reset;
    status(q);
    `CHK(q[3:0], 4'h1)
    `CHK(q[13:8], 6'h01)
    `CHK(q[19:14], 6'h01)
    `CHK({rstLamp, timeEventOut, pvEventOut}, 4'h8)
    bus(1'b0, 8'h3C, 32'h0, q);
    `CHK(q, 32'h0000_0000)
    cmd(4'h1, 2'h0);
    status(q);
    `CHK(q[3:0], 4'h1)
  endtask : t_reset

  task automatic t_hold;
    bus(1'b1, `PMS_OFF_SEGLEN, 32'h0000_0100, q);
    bus(1'b1, `PMS_OFF_LSP, 32'h0000_1234, q);
    bus(1'b1, `PMS_OFF_CFG, 32'h0004_1083, q);
    cmd(4'h5, 2'h1);
    status(q);
    `CHK(q[3:0], 4'h2)
    cmd(4'h1, 2'h2);
    status(q);
    `CHK({q[3:0], pauseLamp}, 5'h9)
    bus(1'b0, `PMS_OFF_TIMER, 32'h0, t1);
    programSp <= 16'h0777;
    repeat (20) @(posedge sys_clk);
    bus(1'b0, `PMS_OFF_TIMER, 32'h0, q);
    `CHK(q, t1)
    `CHK(activeSp, 16'h0100)
    cmd(4'h2, 2'h0);
    repeat (20) @(posedge sys_clk);
    status(q);
    `CHK({q[3:0], pauseLamp}, 5'h4)
    bus(1'b0, `PMS_OFF_TIMER, 32'h0, q);
    `CHK(q > t1 && q < t1 + 32'h10, 1'b1)
  endtask : t_hold

  task automatic t_skip;
    cmd(4'h3, 2'h0);
    status(q);
    `CHK(q[13:8], 6'h02)
    bus(1'b0, `PMS_OFF_TIMER, 32'h0, q);
    `CHK(q < 32'h4, 1'b1)
    cmd(4'h3, 2'h2);
    status(q);
    `CHK(q[13:8], 6'h01)
    cmd(4'h3, 2'h1);
    cmd(4'h1, 2'h2);
    cmd(4'h3, 2'h0);
    status(q);
    `CHK({q[3:0], q[13:8], pauseLamp}, 11'h106)
    cmd(4'h3, 2'h0);
    status(q);
    `CHK(q[3:0], 4'h1)
    bus(1'b1, `PMS_OFF_CFG, 32'h0400_0003, q);
    cmd(4'h5, 2'h2);
    repeat (3) cmd(4'h3, 2'h2);
    status(q);
    `CHK(q[3:0], 4'h8)
    `CHK(q[19:14], 6'h01)
    `CHK({activeSp, timeEventOut}, 17'h02468)
  endtask : t_skip

  task automatic t_am;
    cmd(4'h8, 2'h0);
    `CHK({manLamp, ctrlOut}, 17'h10200)
    autoOut <= 16'h0333;
    bus(1'b1, `PMS_OFF_MANOUT, 32'h0000_0055, q);
    `CHK(ctrlOut, 16'h0055)
    cmd(4'h7, 2'h2);
    `CHK(manLamp, 1'b0)
    reqs <= 6'h08;
    repeat (12) @(posedge sys_clk);
    cmd(4'h7, 2'h0);
    `CHK(manLamp, 1'b1)
    reqs <= 6'h00;
    repeat (12) @(posedge sys_clk);
    cmd(4'h7, 2'h2);
    `CHK(manLamp, 1'b0)
  endtask : t_am

  task automatic t_contact;
    cmd(4'h5, 2'h1);
    reqs <= 6'h20;
    repeat (12) @(posedge sys_clk);
    `CHK(pauseLamp, 1'b1)
    reqs <= 6'h00;
    repeat (12) @(posedge sys_clk);
    `CHK(pauseLamp, 1'b0)
    bus(1'b1, `PMS_OFF_CFG, 32'h2400_0003, q);
    cmd(4'h6, 2'h0);
    status(q);
    `CHK({q[3:0], hideLocalMenu}, 5'h5)
    cmd(4'h6, 2'h1);
    status(q);
    `CHK(q[3:0], 4'h8)
  endtask : t_contact

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  // ----
  // timeout and main sequence
  // ----
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 20000) begin
      mismatches++;
      complete_run();
    end
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_reset();
    t_hold();
    t_skip();
    t_am();
    t_contact();
    complete_run();
  end
endmodule : testbench

bind pms_top pms_chk #(.NPV(NPV), .VW(VW)) pms_chk_i (
  .sys_clk(sys_clk), .arst_n(arst_n), .hreadyout(hreadyout),
  .hresp(hresp), .contAm(contAm), .activeSp(activeSp),
  .bumplessLoad(bumplessLoad), .timeEventOut(timeEventOut),
  .pvEventOut(pvEventOut), .pauseLamp(pauseLamp), .manLamp(manLamp),
  .rstLamp(rstLamp), .showSpView(showSpView),
  .showOutView(showOutView));
